// ===== alarm_regs_pkg.sv
package alarm_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_CAL_ENABLE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_USER_GAIN    = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_USER_OFFSET  = 8'h0a;
  localparam logic [ADDR_W-1:0] OFS_STATUS       = 8'h0b;
  localparam logic [ADDR_W-1:0] OFS_MASK         = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RESPONSE     = 8'h0d;
  localparam logic [ADDR_W-1:0] OFS_ALARM_CODE   = 8'h0e;
  localparam logic [ADDR_W-1:0] OFS_TOGGLE       = 8'h13;

  localparam logic [DATA_W-1:0] STATUS_RESET     = 16'h1000;
  localparam logic [DATA_W-1:0] ZERO_WORD        = 16'h0000;

  localparam int BIT_AUTOLEARN = 12;
  localparam int BIT_WATCHDOG  = 11;
  localparam int BIT_PWR_HI    = 10;
  localparam int BIT_PWR_LO    = 7;
  localparam int BIT_TOGGLE    = 6;
  localparam int BIT_CRC       = 5;
  localparam int BIT_TEMP      = 4;
  localparam int BIT_FAULT_HI  = 3;
  localparam int BIT_FAULT_LO  = 0;
  localparam int CODE_HI       = 15;
  localparam int CODE_LO       = 10;
  localparam int CODE_W        = 6;

  localparam logic [DATA_W-1:0] MASK_VALID     = 16'h083f;
  localparam logic [DATA_W-1:0] RESPONSE_VALID = 16'h00ff;
  localparam logic [DATA_W-1:0] CODE_VALID     = 16'hfc00;

  typedef enum logic [1:0] {
    ACT_NONE    = 2'b00,
    ACT_CODE    = 2'b01,
    ACT_DISABLE = 2'b10,
    ACT_BAD     = 2'b11
  } action_t;

  typedef struct packed {
    action_t crc_watchdog_response;
    action_t open_circuit_response;
    action_t short_circuit_response;
    action_t overtemp_response;
  } response_t;

  typedef struct packed {
    logic       autolearn_done;
    logic       watchdog_fault;
    logic       crc_fault;
    logic       over_temperature;
    logic [3:0] power_ok;
    logic [3:0] open_circuit;
    logic [3:0] short_circuit;
  } events_t;

endpackage : alarm_regs_pkg

// ===== dac_status_alarm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dac_status_alarm_regs
  import alarm_regs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Device conditions
  input  wire events_t           ev,
  // Converter outputs
  output logic                   alarm,
  output logic      [3:0]        code_on_dac,
  output logic                   all_disabled,
  output logic      [CODE_W-1:0] user_alarm_value,
  output logic                   calibration_on,
  output logic      [DATA_W-1:0] gain_applied,
  output logic      [DATA_W-1:0] offset_applied
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] user_gain_word;
  logic [DATA_W-1:0] user_offset_word;
  logic [DATA_W-1:0] fault_status;
  logic [DATA_W-1:0] alarm_pin_mask;
  logic [DATA_W-1:0] alarm_response_select;
  logic [DATA_W-1:0] alarm_code_reg;
  logic              cal_enable;
  logic              user_toggle_bit;
  logic              disable_latch;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire w_gain   = wr && (addr == OFS_USER_GAIN);
  wire w_offset = wr && (addr == OFS_USER_OFFSET);
  wire w_status = wr && (addr == OFS_STATUS);
  wire w_mask   = wr && (addr == OFS_MASK);
  wire w_resp   = wr && (addr == OFS_RESPONSE);
  wire w_code   = wr && (addr == OFS_ALARM_CODE);
  wire w_cal    = wr && (addr == OFS_CAL_ENABLE);
  wire w_toggle = wr && (addr == OFS_TOGGLE);

  response_t resp;
  assign resp = response_t'(alarm_response_select[7:0]);

  // Hardware-set flags: set beats a software clear
  logic [DATA_W-1:0] hw_set;
  always_comb begin
    hw_set                = ZERO_WORD;
    hw_set[BIT_AUTOLEARN] = ev.autolearn_done;
    hw_set[BIT_WATCHDOG]  = ev.watchdog_fault;
    hw_set[BIT_CRC]       = ev.crc_fault;
    hw_set[BIT_TEMP]      = ev.over_temperature;
    hw_set[BIT_FAULT_HI:BIT_FAULT_LO] = ev.open_circuit | ev.short_circuit;
  end

  wire [DATA_W-1:0] status_base = w_status ? wdata : fault_status;
  logic [DATA_W-1:0] next_status;
  always_comb begin
    next_status = status_base | hw_set;
    next_status[BIT_PWR_HI:BIT_PWR_LO] = ev.power_ok;
    next_status[BIT_TOGGLE] = w_toggle ? wdata[0] : user_toggle_bit;
    next_status[DATA_W-1:CODE_HI-2] = '0;
  end

  // ------------------------------------------------------------
  // Alarm pin and actions
  // ------------------------------------------------------------
  wire [3:0] chan_fault = next_status[BIT_FAULT_HI:BIT_FAULT_LO];
  wire next_alarm =
      (next_status[BIT_WATCHDOG] && !alarm_pin_mask[BIT_WATCHDOG]) ||
      (next_status[BIT_CRC]      && !alarm_pin_mask[BIT_CRC])      ||
      (next_status[BIT_TEMP]     && !alarm_pin_mask[BIT_TEMP])     ||
      |(chan_fault & ~alarm_pin_mask[BIT_FAULT_HI:BIT_FAULT_LO]);

  // Invalid code 11 falls through as no action
  wire cw_act   = ev.crc_fault || ev.watchdog_fault;
  wire all_code = (cw_act && resp.crc_watchdog_response == ACT_CODE) ||
                  (ev.over_temperature && resp.overtemp_response == ACT_CODE);
  wire [3:0] per_code =
      (ev.open_circuit  & {4{resp.open_circuit_response  == ACT_CODE}}) |
      (ev.short_circuit & {4{resp.short_circuit_response == ACT_CODE}});
  wire dis_hit =
      (cw_act && resp.crc_watchdog_response == ACT_DISABLE) ||
      (|ev.open_circuit && resp.open_circuit_response == ACT_DISABLE) ||
      (|ev.short_circuit && resp.short_circuit_response == ACT_DISABLE) ||
      (ev.over_temperature && resp.overtemp_response == ACT_DISABLE);
  // Held until reset: a clearing condition does not re-enable outputs
  wire next_disable = disable_latch || dis_hit;
  wire [3:0] next_code_on = {4{all_code}} | per_code;

  // Corrections only pass while calibration is enabled
  wire [DATA_W-1:0] next_gain_applied   = cal_enable ? user_gain_word   : ZERO_WORD;
  wire [DATA_W-1:0] next_offset_applied = cal_enable ? user_offset_word : ZERO_WORD;

  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    unique case (addr)
      OFS_CAL_ENABLE:  next_rdata = {15'h0000, cal_enable};
      OFS_USER_GAIN:   next_rdata = user_gain_word;
      OFS_USER_OFFSET: next_rdata = user_offset_word;
      OFS_STATUS:      next_rdata = fault_status;
      OFS_MASK:        next_rdata = alarm_pin_mask;
      OFS_RESPONSE:    next_rdata = alarm_response_select;
      OFS_ALARM_CODE:  next_rdata = alarm_code_reg;
      OFS_TOGGLE:      next_rdata = {15'h0000, user_toggle_bit};
      default:         next_rdata = ZERO_WORD;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      user_gain_word        <= ZERO_WORD;
      user_offset_word      <= ZERO_WORD;
      fault_status          <= STATUS_RESET;
      alarm_pin_mask        <= ZERO_WORD;
      alarm_response_select <= ZERO_WORD;
      alarm_code_reg        <= ZERO_WORD;
      cal_enable            <= 1'b0;
      user_toggle_bit       <= 1'b0;
    end else begin
      if (w_gain)   user_gain_word        <= wdata;
      if (w_offset) user_offset_word      <= wdata;
      if (w_mask)   alarm_pin_mask        <= wdata & MASK_VALID;
      if (w_resp)   alarm_response_select <= wdata & RESPONSE_VALID;
      if (w_code)   alarm_code_reg        <= wdata & CODE_VALID;
      if (w_cal)    cal_enable            <= wdata[0];
      if (w_toggle) user_toggle_bit       <= wdata[0];
      fault_status <= next_status;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata            <= ZERO_WORD;
      alarm            <= 1'b0;
      code_on_dac      <= 4'h0;
      all_disabled     <= 1'b0;
      disable_latch    <= 1'b0;
      user_alarm_value <= 6'h00;
      calibration_on   <= 1'b0;
      gain_applied     <= ZERO_WORD;
      offset_applied   <= ZERO_WORD;
    end else begin
      rdata            <= rd ? next_rdata : ZERO_WORD;
      alarm            <= next_alarm;
      code_on_dac      <= next_code_on;
      disable_latch    <= next_disable;
      all_disabled     <= next_disable;
      user_alarm_value <= alarm_code_reg[CODE_HI:CODE_LO];
      calibration_on   <= cal_enable;
      gain_applied     <= next_gain_applied;
      offset_applied   <= next_offset_applied;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_gain_rw;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == OFS_USER_GAIN) ##1 !w_gain ##1 (rd && addr == OFS_USER_GAIN) |=> rdata == $past(wdata, 3);
  endproperty
  a_gain_rw: assert property (p_gain_rw) else $error("gain readback wrong");

  property p_offset_applied;
    @(posedge clk) disable iff (!nrst)
      cal_enable |=> offset_applied == $past(user_offset_word);
  endproperty
  a_offset_applied: assert property (p_offset_applied) else $error("offset not applied");

  property p_no_cal;
    @(posedge clk) disable iff (!nrst)
      !cal_enable |=> gain_applied == ZERO_WORD && offset_applied == ZERO_WORD;
  endproperty
  a_no_cal: assert property (p_no_cal) else $error("correction while disabled");

  property p_wdt_sticky;
    @(posedge clk) disable iff (!nrst)
      ev.watchdog_fault |=> fault_status[BIT_WATCHDOG];
  endproperty
  a_wdt_sticky: assert property (p_wdt_sticky) else $error("watchdog flag lost");

  property p_crc_alarm;
    @(posedge clk) disable iff (!nrst)
      ev.crc_fault && !alarm_pin_mask[BIT_CRC] |=> alarm;
  endproperty
  a_crc_alarm: assert property (p_crc_alarm) else $error("crc alarm missing");

  property p_masked_quiet;
    @(posedge clk) disable iff (!nrst)
      (alarm_pin_mask == MASK_VALID && !w_mask) |=> !alarm;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("alarm while all masked");

  property p_power_ok;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> fault_status[BIT_PWR_HI:BIT_PWR_LO] == $past(ev.power_ok);
  endproperty
  a_power_ok: assert property (p_power_ok) else $error("power good mismatch");

  property p_disable_holds;
    @(posedge clk) disable iff (!nrst)
      all_disabled |=> all_disabled [*3];
  endproperty
  a_disable_holds: assert property (p_disable_holds) else $error("disable released");

  property p_bad_code;
    @(posedge clk) disable iff (!nrst)
      (resp == response_t'(8'hff) && !disable_latch) |=> !all_disabled && code_on_dac == 4'h0;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("invalid code acted");

  property p_gain_store;
    @(posedge clk) disable iff (!nrst)
      w_gain |=> user_gain_word == $past(wdata);
  endproperty
  a_gain_store: assert property (p_gain_store) else $error("gain write lost");

  property p_gain_hold;
    @(posedge clk) disable iff (!nrst)
      !w_gain |=> $stable(user_gain_word);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed without write");

  property p_offset_store;
    @(posedge clk) disable iff (!nrst)
      w_offset |=> user_offset_word == $past(wdata);
  endproperty
  a_offset_store: assert property (p_offset_store) else $error("offset write lost");

  property p_offset_hold;
    @(posedge clk) disable iff (!nrst)
      !w_offset |=> $stable(user_offset_word);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset changed without write");

  property p_gain_applied;
    @(posedge clk) disable iff (!nrst)
      cal_enable |=> gain_applied == $past(user_gain_word);
  endproperty
  a_gain_applied: assert property (p_gain_applied) else $error("gain not applied");

  property p_wdt_alarm;
    @(posedge clk) disable iff (!nrst)
      ev.watchdog_fault && !alarm_pin_mask[BIT_WATCHDOG] |=> alarm;
  endproperty
  a_wdt_alarm: assert property (p_wdt_alarm) else $error("watchdog alarm missing");

  property p_temp_alarm;
    @(posedge clk) disable iff (!nrst)
      ev.over_temperature && !alarm_pin_mask[BIT_TEMP] |=> alarm;
  endproperty
  a_temp_alarm: assert property (p_temp_alarm) else $error("temperature alarm missing");

  property p_chan_alarm;
    @(posedge clk) disable iff (!nrst)
      |((ev.open_circuit | ev.short_circuit) & ~alarm_pin_mask[BIT_FAULT_HI:BIT_FAULT_LO]) |=> alarm;
  endproperty
  a_chan_alarm: assert property (p_chan_alarm) else $error("channel alarm missing");

  property p_crc_sticky;
    @(posedge clk) disable iff (!nrst)
      ev.crc_fault |=> fault_status[BIT_CRC];
  endproperty
  a_crc_sticky: assert property (p_crc_sticky) else $error("crc flag lost");

  property p_temp_sticky;
    @(posedge clk) disable iff (!nrst)
      ev.over_temperature |=> fault_status[BIT_TEMP];
  endproperty
  a_temp_sticky: assert property (p_temp_sticky) else $error("temperature flag lost");

  property p_chan0_sticky;
    @(posedge clk) disable iff (!nrst)
      ev.open_circuit[0] || ev.short_circuit[0] |=> fault_status[BIT_FAULT_LO];
  endproperty
  a_chan0_sticky: assert property (p_chan0_sticky) else $error("channel 0 flag lost");

  property p_chan3_sticky;
    @(posedge clk) disable iff (!nrst)
      ev.open_circuit[3] || ev.short_circuit[3] |=> fault_status[BIT_FAULT_HI];
  endproperty
  a_chan3_sticky: assert property (p_chan3_sticky) else $error("channel 3 flag lost");

  property p_autolearn;
    @(posedge clk) disable iff (!nrst)
      ev.autolearn_done |=> fault_status[BIT_AUTOLEARN];
  endproperty
  a_autolearn: assert property (p_autolearn) else $error("autolearn flag lost");

  property p_toggle_echo;
    @(posedge clk) disable iff (!nrst)
      fault_status[BIT_TOGGLE] == user_toggle_bit;
  endproperty
  a_toggle_echo: assert property (p_toggle_echo) else $error("toggle echo wrong");

  property p_status_reserved;
    @(posedge clk) disable iff (!nrst)
      fault_status[DATA_W-1:BIT_AUTOLEARN+1] == '0;
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("status reserved bits set");

  property p_mask_reserved;
    @(posedge clk) disable iff (!nrst)
      (alarm_pin_mask & ~MASK_VALID) == ZERO_WORD;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("mask reserved bits set");

  property p_resp_reserved;
    @(posedge clk) disable iff (!nrst)
      (alarm_response_select & ~RESPONSE_VALID) == ZERO_WORD;
  endproperty
  a_resp_reserved: assert property (p_resp_reserved) else $error("response upper byte set");

  property p_code_reserved;
    @(posedge clk) disable iff (!nrst)
      (alarm_code_reg & ~CODE_VALID) == ZERO_WORD;
  endproperty
  a_code_reserved: assert property (p_code_reserved) else $error("code reserved bits set");

  property p_code_out;
    @(posedge clk) disable iff (!nrst)
      !w_code |=> user_alarm_value == alarm_code_reg[CODE_HI:CODE_LO];
  endproperty
  a_code_out: assert property (p_code_out) else $error("alarm code output wrong");

  property p_status_read;
    @(posedge clk) disable iff (!nrst)
      rd && addr == OFS_STATUS |=> rdata == $past(fault_status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_cw_disable;
    @(posedge clk) disable iff (!nrst)
      ev.crc_fault && resp.crc_watchdog_response == ACT_DISABLE |=> all_disabled;
  endproperty
  a_cw_disable: assert property (p_cw_disable) else $error("crc disable missing");

  property p_open_code;
    @(posedge clk) disable iff (!nrst)
      resp.open_circuit_response == ACT_CODE |=> (code_on_dac & $past(ev.open_circuit)) == $past(ev.open_circuit);
  endproperty
  a_open_code: assert property (p_open_code) else $error("open circuit code missing");

  property p_short_code;
    @(posedge clk) disable iff (!nrst)
      resp.short_circuit_response == ACT_CODE |=> (code_on_dac & $past(ev.short_circuit)) == $past(ev.short_circuit);
  endproperty
  a_short_code: assert property (p_short_code) else $error("short circuit code missing");

  property p_temp_disable;
    @(posedge clk) disable iff (!nrst)
      ev.over_temperature && resp.overtemp_response == ACT_DISABLE |=> all_disabled;
  endproperty
  a_temp_disable: assert property (p_temp_disable) else $error("temperature disable missing");

  c_alarm:   cover property (@(posedge clk) disable iff (!nrst) $rose(alarm));
  c_disable: cover property (@(posedge clk) disable iff (!nrst) $rose(all_disabled));
  c_code:    cover property (@(posedge clk) disable iff (!nrst) code_on_dac != 4'h0);
  c_read:    cover property (@(posedge clk) disable iff (!nrst) rd && addr == OFS_USER_GAIN);
  c_latched: cover property (@(posedge clk) disable iff (!nrst) all_disabled && !dis_hit);

endmodule : dac_status_alarm_regs
`default_nettype wire

// ===== host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model
  import alarm_regs_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register port
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd,
  input  wire logic [DATA_W-1:0] rdata
);
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Idle address is inverted after each transfer, and data after a write, so stale values are never mistaken for live ones
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
endmodule : host_port_model
`default_nettype wire

// ===== dac_status_alarm_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dac_status_alarm_regs_bench;
  import alarm_regs_pkg::*;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wr;
  logic              rd;
  events_t           ev;
  logic              alarm;
  logic [3:0]        code_on_dac;
  logic              all_disabled;
  logic [CODE_W-1:0] user_alarm_value;
  logic              calibration_on;
  logic [DATA_W-1:0] gain_applied;
  logic [DATA_W-1:0] offset_applied;
  int                fails;
  int                compares;
  int                mdl[int];
  int                kf[4] = '{1, 4, 5, 2};
  int                exp_dac[4] = '{15, 2, 4, 15};
  int                regs[$] = '{9, 10, 11, 12, 13, 14, 32};

  dac_status_alarm_regs i_dac_status_alarm_regs(.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .ev, .alarm,
    .code_on_dac, .all_disabled, .user_alarm_value, .calibration_on, .gain_applied, .offset_applied);
  host_port_model i_host_port_model(.clk, .addr, .wdata, .wr, .rd, .rdata);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    ev   <= '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    mdl.delete();
    mdl[11] = 'h1000;
  endtask : do_reset
  // Falling edge, so updates of the last rising edge have landed
  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_n
  task automatic wreg(int a, int d);
    i_host_port_model.wr_reg(a[7:0], d[15:0]);
    case (a)
      9, 10: mdl[a] = d & 'hffff;
      11: mdl[a] = d & 'h183f | mdl[a] & 'h07c0;
      12: mdl[a] = d & MASK_VALID;
      13: mdl[a] = d & RESPONSE_VALID;
      14: mdl[a] = d & CODE_VALID;
      19: mdl[11] = mdl[11] & ~'h40 | (d & 1) << 6;
      default: ;
    endcase
  endtask : wreg
  task automatic rchk(int a);
    logic [DATA_W-1:0] d;
    i_host_port_model.rd_reg(a[7:0], d);
    check("rdata", d, mdl.exists(a) ? mdl[a] : 0);
  endtask : rchk
  task automatic set_ev(int k, bit on);
    @(posedge clk);
    case (k)
      0: ev.watchdog_fault <= on;
      1: ev.crc_fault <= on;
      2: ev.over_temperature <= on;
      7: ev.autolearn_done <= on;
      default: if (k[0]) ev.short_circuit[k-3] <= on; else ev.open_circuit[k-3] <= on;
    endcase
  endtask : set_ev

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int sb;
    int r;
    nrst = 1'b0;
    ev = '0;
    r = $urandom(32'h3c23d8e3);
    do_reset();
    foreach (regs[i]) rchk(regs[i]);
    check("all_disabled", all_disabled, 0);
    foreach (regs[i]) wreg(regs[i] == 11 ? 19 : regs[i], $urandom);
    ev.power_ok <= 4'($urandom);
    wait_n(2);
    mdl[11] = mdl[11] & 'h187f | int'(ev.power_ok) << 7;
    foreach (regs[i]) rchk(regs[i]);
    check("user_alarm_value", user_alarm_value, mdl[14] >> 10);
    check("gain_applied", gain_applied, 0);
    wreg(8, 1);
    wreg(9, $urandom);
    rchk(9);
    wait_n(3);
    check("calibration_on", calibration_on, 1);
    check("gain_applied", gain_applied, mdl[9]);
    check("offset_applied", offset_applied, mdl[10]);
    do_reset();
    for (int k = 0; k < 7; k++)
      for (int m = 0; m < 2; m++) begin
        sb = k == 0 ? 11 : k == 1 ? 5 : k == 2 ? 4 : k - 3;
        wreg(12, m << sb);
        set_ev(k, 1);
        set_ev(k, 0);
        mdl[11] |= 1 << sb;
        wait_n(2);
        check("alarm", alarm, !m);
        rchk(11);
        wreg(11, 0);
        wait_n(2);
        check("alarm", alarm, 0);
      end
    set_ev(7, 1);
    set_ev(7, 0);
    mdl[11] |= 'h1000;
    wait_n(1);
    rchk(11);
    for (int f = 0; f < 4; f++)
      for (int c = 0; c < 4; c++) begin
        wreg(13, c << (6 - 2 * f));
        set_ev(kf[f], 1);
        wait_n(3);
        if (c != 2) check("code_on_dac", code_on_dac, c == 1 ? exp_dac[f] : 0);
        check("all_disabled", all_disabled, c == 2);
        set_ev(kf[f], 0);
        wait_n(3);
        check("all_disabled", all_disabled, c == 2);
        if (c != 2) check("code_on_dac", code_on_dac, 0);
        if (c == 2) do_reset(); else wreg(11, 0);
      end
    report_and_stop();
  end
endmodule : dac_status_alarm_regs_bench
`default_nettype wire
